// ==== read_protection_gate.sv ====
// code read protection gate: level decode, debug and loader gating
// Behaviour
// - level chosen by matching the code word held in the dedicated flash location.
// - application flash calls pass ungated at every level.
// - three protection levels, each with its own restrictions.
// - level one blocks debug; loader limited, sector zero untouchable.
// - level two blocks debug; loader only ID, whole erase, then reprogram.
// - level three refuses all debug, and serial loader access until the application re-invokes the loader.
// - level three ignores the boot override pin at reset.
// - level three still honours the application's loader re-invocation request.
`timescale 1ns/100ps
`default_nettype none
`include "read_protection_defs.svh"
module read_protection_gate (
  input  wire logic                         CLK_SYS_I,
  input  wire logic                         RST_N_I,
  input  wire logic [`RP_WORD_W-1:0]        CODE_WORD_I,
  input  wire logic                         CODE_VALID_I,
  input  wire logic                         BOOT_OVERRIDE_PIN_I,
  input  wire logic                         REINVOKE_LOADER_I,
  input  wire logic                         JTAG_REQ_I,
  input  wire read_protection_pkg::loader_req_s LOADER_REQ_I,
  input  wire logic                         CHIP_ERASED_I,
  input  wire logic                         APP_FLASH_REQ_I,
  output logic [1:0]                        LEVEL_O,
  output logic                              LEVEL_VALID_O,
  output logic                              JTAG_EN_O,
  output logic                              ENTER_LOADER_O,
  output logic                              LOADER_GRANT_O,
  output logic                              LOADER_DENY_O,
  output logic                              APP_FLASH_GRANT_O
);
  import read_protection_pkg::*;

  logic        rst_s1_q, rst_s2_q;
  logic        rst_n;
  prot_level_e level_d, level_q;
  logic        valid_d, valid_q;
  logic        boot_d, boot_q;
  logic        jtag_d, jtag_q;
  logic        app_d, app_q;
  logic        lreq_valid;
  loader_req_s lreq;

  // reset release through two stages
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // level latched once per reset, when flash delivers the word
  always_comb begin
    level_d = level_q;
    valid_d = valid_q;
    boot_d  = 1'b0;
    if (!valid_q && CODE_VALID_I) begin
      valid_d = 1'b1;
      if (CODE_WORD_I == `RP_CODE_ONE) begin
        level_d = LVL_ONE;
      end else if (CODE_WORD_I == `RP_CODE_TWO) begin
        level_d = LVL_TWO;
      end else if (CODE_WORD_I == `RP_CODE_THREE) begin
        level_d = LVL_THREE;
      end else begin
        level_d = LVL_NONE;
      end
      // strap sampled at the decode, after reset release
      boot_d = BOOT_OVERRIDE_PIN_I & (level_d != LVL_THREE);
    end
    if (valid_q && REINVOKE_LOADER_I) begin
      boot_d = 1'b1;
    end
  end

  always_comb begin
    // debug does not pass until the level is known, so no early debug window exists
    jtag_d = valid_q & (level_q == LVL_NONE);
    app_d  = APP_FLASH_REQ_I;
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= LVL_NONE;
      valid_q <= 1'b0;
      boot_q  <= 1'b0;
      jtag_q  <= 1'b0;
      app_q   <= 1'b0;
    end else begin
      level_q <= level_d;
      valid_q <= valid_d;
      boot_q  <= boot_d;
      jtag_q  <= jtag_d;
      app_q   <= app_d;
    end
  end

  // level three refuses the loader unless the application asked for it
  logic reinvoked_d, reinvoked_q;
  always_comb begin
    reinvoked_d = reinvoked_q | (valid_q & REINVOKE_LOADER_I);
  end
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      reinvoked_q <= 1'b0;
    end else begin
      reinvoked_q <= reinvoked_d;
    end
  end

  // a re-invoked loader at level three runs the level one command set
  prot_level_e filter_level;
  always_comb begin
    filter_level = level_q;
    if (level_q == LVL_THREE && reinvoked_q) begin
      filter_level = LVL_ONE;
    end
  end

  always_comb begin
    lreq_valid   = LOADER_REQ_I.valid & valid_q;
    lreq         = LOADER_REQ_I;
    lreq.valid   = lreq_valid;
  end

  loader_cmd_filter u_filter (
    .clk_i         (CLK_SYS_I),
    .rst_n_i       (rst_n),
    .level_i       (filter_level),
    .erased_i      (CHIP_ERASED_I),
    .req_i         (lreq),
    .grant_o       (LOADER_GRANT_O),
    .deny_o        (LOADER_DENY_O),
    .erased_seen_o ()
  );

  assign LEVEL_O           = level_q;
  assign LEVEL_VALID_O     = valid_q;
  assign JTAG_EN_O         = jtag_q & JTAG_REQ_I;
  assign ENTER_LOADER_O    = boot_q;
  assign APP_FLASH_GRANT_O = app_q;
endmodule : read_protection_gate
`default_nettype wire

// ==== read_protection_defs.svh ====
// constants for the code read protection gate
`ifndef READ_PROTECTION_DEFS_SVH
`define READ_PROTECTION_DEFS_SVH
`define RP_WORD_W        32
`define RP_CODE_ONE      32'h1234_5678
`define RP_CODE_TWO      32'h8765_4321
`define RP_CODE_THREE    32'h4321_8765
`define RP_SECTOR_W      5
`define RP_SECTOR_ZERO   5'h00
`define RP_CMD_W         4
`define RP_CMD_READ      4'h0
`define RP_CMD_WRITE     4'h1
`define RP_CMD_ERASE     4'h2
`define RP_CMD_ERASE_ALL 4'h3
`define RP_CMD_GO        4'h4
`define RP_CMD_PREPARE   4'h5
`define RP_CMD_ID        4'h6
`define RP_CMD_BLANK     4'h7
`define RP_CMD_COMPARE   4'h8
`endif

// ==== read_protection_pkg.sv ====
// types for the code read protection gate
package read_protection_pkg;
  typedef enum logic [1:0] {
    LVL_NONE  = 2'b00,
    LVL_ONE   = 2'b01,
    LVL_TWO   = 2'b10,
    LVL_THREE = 2'b11
  } prot_level_e;

  typedef struct packed {
    logic       valid;
    logic [3:0] cmd;
    logic [4:0] sector;
  } loader_req_s;
endpackage : read_protection_pkg

// ==== loader_cmd_filter.sv ====
// serial loader command filter per protection level
`timescale 1ns/100ps
`default_nettype none
`include "read_protection_defs.svh"
module loader_cmd_filter (
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  input  wire read_protection_pkg::prot_level_e  level_i,
  input  wire logic                              erased_i,
  input  wire read_protection_pkg::loader_req_s  req_i,
  output logic                                   grant_o,
  output logic                                   deny_o,
  output logic                                   erased_seen_o
);
  import read_protection_pkg::*;

  logic allow;
  logic grant_d, grant_q, deny_d, deny_q;
  logic erased_d, erased_q;

  always_comb begin
    allow = 1'b0;
    case (level_i)
      LVL_NONE: allow = 1'b1;
      LVL_ONE: begin
        // no erase of the whole part; write, erase, prepare and blank check may not touch sector zero
        case (req_i.cmd)
          `RP_CMD_WRITE, `RP_CMD_ERASE, `RP_CMD_PREPARE,
          `RP_CMD_BLANK: allow = (req_i.sector != `RP_SECTOR_ZERO);
          `RP_CMD_ID, `RP_CMD_GO: allow = 1'b1;
          default: allow = 1'b0;
        endcase
      end
      LVL_TWO: begin
        // writes only after a whole-chip erase this session
        case (req_i.cmd)
          `RP_CMD_ERASE_ALL, `RP_CMD_ID: allow = 1'b1;
          `RP_CMD_WRITE, `RP_CMD_PREPARE, `RP_CMD_BLANK: allow = erased_q | erased_i;
          default: allow = 1'b0;
        endcase
      end
      default: allow = 1'b0;
    endcase
  end

  always_comb begin
    grant_d  = req_i.valid & allow;
    deny_d   = req_i.valid & ~allow;
    erased_d = erased_q | erased_i | (grant_d && req_i.cmd == `RP_CMD_ERASE_ALL);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      grant_q  <= 1'b0;
      deny_q   <= 1'b0;
      erased_q <= 1'b0;
    end else begin
      grant_q  <= grant_d;
      deny_q   <= deny_d;
      erased_q <= erased_d;
    end
  end

  assign grant_o       = grant_q;
  assign deny_o        = deny_q;
  assign erased_seen_o = erased_q;
endmodule : loader_cmd_filter
`default_nettype wire

// ==== read_protection_gate_chk.sv ====
// port assertions for the read protection gate
`timescale 1ns/100ps
`default_nettype none
`include "read_protection_defs.svh"
module read_protection_gate_chk (
  input wire logic                         CLK_SYS_I,
  input wire logic                         RST_N_I,
  input wire logic                         REINVOKE_LOADER_I,
  input wire read_protection_pkg::loader_req_s LOADER_REQ_I,
  input wire logic [1:0]                   LEVEL_O,
  input wire logic                         LEVEL_VALID_O,
  input wire logic                         JTAG_EN_O,
  input wire logic                         ENTER_LOADER_O,
  input wire logic                         LOADER_GRANT_O,
  input wire logic                         LOADER_DENY_O
);
  import read_protection_pkg::*;
  logic reinv_d;
  logic reinv_q;
  // level three loader stays shut until the application reopens it
  always_comb reinv_d = reinv_q | (REINVOKE_LOADER_I & LEVEL_VALID_O);
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) reinv_q <= 1'h0;
    else reinv_q <= reinv_d;
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_wipe;
    LEVEL_VALID_O && LEVEL_O == 2'h2 && LOADER_REQ_I.valid && LOADER_REQ_I.cmd == `RP_CMD_ERASE_ALL;
  endsequence
  sequence s_write;
    LOADER_REQ_I.valid && LOADER_REQ_I.cmd == `RP_CMD_WRITE;
  endsequence
  chk_level_hold: assert property (LEVEL_VALID_O |=> LEVEL_VALID_O && $stable(LEVEL_O))
    else $error("level changed after decode");
  chk_one_answer: assert property (LEVEL_VALID_O && LOADER_REQ_I.valid |=> LOADER_GRANT_O != LOADER_DENY_O)
    else $error("loader request not answered once");
  chk_jtag_shut: assert property (LEVEL_VALID_O && LEVEL_O != 2'h0 |-> !JTAG_EN_O)
    else $error("debug open at protected level");
  chk_sector_zero: assert property (LEVEL_VALID_O && LEVEL_O == 2'h1 && LOADER_REQ_I.sector == 5'h00 ##0 s_write |=> LOADER_DENY_O)
    else $error("sector zero write not denied");
  chk_wipe_write: assert property (s_wipe ##1 s_write |=> LOADER_GRANT_O)
    else $error("write after full erase not granted");
  chk_lvl3_deny: assert property (LEVEL_VALID_O && LEVEL_O == 2'h3 && !reinv_q && LOADER_REQ_I.valid |=> LOADER_DENY_O)
    else $error("loader served at level three");
  chk_boot_pin: assert property ($rose(LEVEL_VALID_O) && LEVEL_O == 2'h3 && !$past(REINVOKE_LOADER_I) |-> !ENTER_LOADER_O)
    else $error("boot pin honoured at level three");
  chk_reinvoke: assert property (LEVEL_VALID_O && REINVOKE_LOADER_I |=> ENTER_LOADER_O)
    else $error("reinvoke request ignored");
endmodule : read_protection_gate_chk
`default_nettype wire

// ==== loader_host_model.sv ====
// serial loader host and debugger model
`timescale 1ns/100ps
`default_nettype none
module loader_host_model (
  input  wire logic                           clk_i,
  output var read_protection_pkg::loader_req_s req_o,
  output var logic                            jtag_req_o
);
  import read_protection_pkg::*;
  initial begin
    req_o = '0;
    jtag_req_o = 1'h0;
  end
  // called at a falling edge; rel low keeps the bus for a back-to-back request
  task send(input logic [3:0] cmd, input logic [4:0] sec, input logic rel);
    req_o = '{1'h1, cmd, sec};
    @(negedge clk_i);
    if (rel) req_o = '{1'h0, ~cmd, ~sec};
  endtask : send
  // test clock itself not modelled, only a slow held request
  task jtag(input logic on);
    jtag_req_o = on;
  endtask : jtag
endmodule : loader_host_model
`default_nettype wire

// ==== read_protection_gate_tb.sv ====
// testbench for the read protection gate
`timescale 1ns/100ps
`default_nettype none
`include "read_protection_defs.svh"
module read_protection_gate_tb;
  import read_protection_pkg::*;
  logic clk, rst_n, code_vld, boot, reinv, erased, app, jreq;
  logic [31:0] code;
  loader_req_s req;
  logic [1:0] lvl;
  logic lvl_v, jen, enter, gnt, dny, app_g;
  int mismatches = 0;
  int tests_run = 0;
  read_protection_gate dut_u (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CODE_WORD_I(code),
    .CODE_VALID_I(code_vld), .BOOT_OVERRIDE_PIN_I(boot), .REINVOKE_LOADER_I(reinv),
    .JTAG_REQ_I(jreq), .LOADER_REQ_I(req), .CHIP_ERASED_I(erased), .APP_FLASH_REQ_I(app),
    .LEVEL_O(lvl), .LEVEL_VALID_O(lvl_v), .JTAG_EN_O(jen), .ENTER_LOADER_O(enter),
    .LOADER_GRANT_O(gnt), .LOADER_DENY_O(dny), .APP_FLASH_GRANT_O(app_g));
  loader_host_model host_u (.clk_i(clk), .req_o(req), .jtag_req_o(jreq));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  // full reset each time, the level only latches once per reset
  task start(input logic [31:0] c, input logic pin, input logic [1:0] exp, input logic ent);
    rst_n = 1'h0;
    boot = pin;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    repeat (4) @(negedge clk);
    code = c;
    code_vld = 1'h1;
    @(negedge clk);
    code_vld = 1'h0;
    code = ~c;
    check("level", {lvl_v, lvl}, {1'h1, exp});
    check("enter loader", enter, ent);
  endtask : start
  task ld(input logic [3:0] c, input logic [4:0] s, input logic g);
    host_u.send(c, s, 1'h1);
    check("loader grant", {gnt, dny}, {g, ~g});
  endtask : ld
  task dbg(input logic exp);
    host_u.jtag(1'h1);
    repeat (3) @(negedge clk);
    check("debug enable", jen, exp);
    host_u.jtag(1'h0);
    app = 1'h1;
    @(negedge clk);
    app = 1'h0;
    check("app flash grant", app_g, 1'h1);
    @(negedge clk);
    check("app flash idle", app_g, 1'h0);
  endtask : dbg
  task t_none;
    start(32'h0000_0000, 1'h1, 2'h0, 1'h1);
    dbg(1'h1);
    ld(`RP_CMD_WRITE, 5'h00, 1'h1);
    $display("test none done");
  endtask : t_none
  task t_one;
    start(`RP_CODE_ONE, 1'h0, 2'h1, 1'h0);
    dbg(1'h0);
    ld(`RP_CMD_WRITE, 5'h00, 1'h0);
    ld(`RP_CMD_WRITE, 5'h03, 1'h1);
    ld(`RP_CMD_READ, 5'h03, 1'h0);
    $display("test level one done");
  endtask : t_one
  task t_two;
    start(`RP_CODE_TWO, 1'h1, 2'h2, 1'h1);
    dbg(1'h0);
    ld(`RP_CMD_WRITE, 5'h03, 1'h0);
    host_u.send(`RP_CMD_ERASE_ALL, 5'h00, 1'h0);
    check("erase all grant", gnt, 1'h1);
    ld(`RP_CMD_WRITE, 5'h03, 1'h1);
    code = `RP_CODE_THREE;
    code_vld = 1'h1;
    @(negedge clk);
    code_vld = 1'h0;
    @(negedge clk);
    check("later code word", lvl, 2'h2);
    // erase reported by flash opens writes too
    start(`RP_CODE_TWO, 1'h0, 2'h2, 1'h0);
    erased = 1'h1;
    @(negedge clk);
    erased = 1'h0;
    ld(`RP_CMD_WRITE, 5'h03, 1'h1);
    $display("test level two done");
  endtask : t_two
  task t_three;
    start(`RP_CODE_THREE, 1'h1, 2'h3, 1'h0);
    dbg(1'h0);
    ld(`RP_CMD_ID, 5'h00, 1'h0);
    reinv = 1'h1;
    @(negedge clk);
    reinv = 1'h0;
    check("reinvoke enter", enter, 1'h1);
    ld(`RP_CMD_ID, 5'h00, 1'h1);
    $display("test level three done");
  endtask : t_three
  initial begin
    {rst_n, code_vld, boot, reinv, erased, app} = '0;
    code = '0;
    t_none;
    t_one;
    t_two;
    t_three;
    finish_test;
  end
  // about a hundred and forty cycles expected, ten thousand allowed
  initial begin
    #200000;
    mismatches++;
    finish_test;
  end
endmodule : read_protection_gate_tb
bind read_protection_gate read_protection_gate_chk chk_u (.*);
`default_nettype wire
